// file: hw/supervisor_cfg.svh
// Timing and level constants of the supply supervisor reset generator
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define CLK_PERIOD_PS      4000
`define VREF_MV            300
`define HYST_MV            3
`define TRST_MIN_MS        140
`define TRST_MAX_MS        280
`define TRST_CYCLES        ((`TRST_MIN_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
`define GLITCH_NS          20000
`define GLITCH_CYCLES      ((`GLITCH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DEEP_MV            100
`define GLITCH_DEEP_CYCLES ((`GLITCH_CYCLES) / 4)
`define POL_HIGH           2'h0
`define POL_LOW_PP         2'h1
`define POL_LOW_OD         2'h2
`endif

// file: hw/supervisor_pkg.sv
// Types shared by the supply supervisor reset generator
package supervisor_pkg;
    typedef enum logic [1:0] {ST_HOLD, ST_TIMING, ST_RUN} rst_state_e;
    typedef struct packed {
        logic level;
        logic out;
        logic oe;
    } rst_pin_s;
endpackage

// file: hw/supply_supervisor_reset_gen.sv
// Reset generator: undervoltage and manual reset feed a timed reset output
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_cfg.svh"
// Functional notes
// - Monitor below 300 mV reference flags undervoltage and starts reset.
// - Undervoltage decision has hysteresis against chatter.
// - Reset stays asserted while manual reset low or undervoltage present.
// - After both causes clear, reset holds at least the timeout.
// - Power-on yields a reset pulse released after the timeout.
// - Manual reset low for at least two cycles asserts reset five cycles later, in any state.
// - Unconnected manual reset input counts as released (high).
// - Brief dips below threshold ignored; deeper dips tolerated shorter.
// - Open-drain variant only pulls reset low, else releases.
module supply_supervisor_reset_gen
    import supervisor_pkg::*;
#(
    parameter logic [1:0] POLARITY = `POL_LOW_PP,
    parameter int         MW       = 12,
    parameter int         TRST     = `TRST_CYCLES,
    parameter int         GLITCH   = `GLITCH_CYCLES,
    parameter int         GDEEP    = `GLITCH_DEEP_CYCLES,
    parameter int         TW       = 26
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    // Monitored level, digitised, in millivolts
    input  wire logic [MW-1:0] level_mv,
    // Manual reset, with its pin-connected flag
    input  wire logic          manual_reset_n,
    input  wire logic          manual_reset_n_oe,
    // Reset output pin and internal reset state
    output logic               rst_out,
    output logic               rst_oe,
    output logic               rst_active_r
);
    // Latency budget, in clk_sys cycles:
    //   manual reset pin to reset state   five (three sync flops, the
    //                                     agreement filter, the state);
    //                                     far below what a switch or a
    //                                     logic source could notice
    //   level below the trip point        GLITCH, or GDEEP on deep dips,
    //                                     then one more to reach the pin
    //   last cause gone to release        TRST plus the path above
    // Every route ends in the one state register, so all polarity
    // variants switch on the same edge.

    // Glitch counter width inside the undervoltage filter
    localparam int            GW        = 16;
    // Timer value at which the hold time has fully elapsed
    localparam logic [TW-1:0] TMR_END   = TW'(TRST);
    // Synchroniser depth on the manual reset pin
    localparam int            SYNC_N    = 3;
    // Polarity decode, fixed at build time
    localparam logic          POL_IS_HI = (POLARITY == `POL_HIGH);
    localparam logic          POL_IS_OD = (POLARITY == `POL_LOW_OD);

    rst_state_e        state_r;
    rst_state_e        state_nxt;
    logic [TW-1:0]     tmr_r;
    logic [TW-1:0]     tmr_nxt;
    logic [SYNC_N-1:0] mr_sync_r;
    logic [SYNC_N-1:0] mr_sync_nxt;
    logic              mr_low_r;
    logic              mr_low_nxt;
    logic              uv;
    logic              pin_out_nxt;
    logic              pin_oe_nxt;
    rst_pin_s          pin_nxt;
    rst_pin_s          pin_rst;

    // Undervoltage comparison, hysteresis and transient rejection
    uv_detect #(
        .MW     (MW),
        .CW     (GW),
        .GLITCH (GLITCH),
        .GDEEP  (GDEEP)
    ) u_uv (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .level_mv (level_mv),
        .uv_r     (uv)
    );

    // Floating pin is seen as released, as the weak pull-up would do
    wire mr_pin      = manual_reset_n_oe ? manual_reset_n : 1'b1;

    // The pin is asynchronous, so it never reaches the state logic raw:
    // a level only counts once the last two flops agree. The few cycles
    // this costs are the price of a metastability-free reset path.
    assign mr_sync_nxt = {mr_sync_r[SYNC_N-2:0], mr_pin};
    wire mr_agree    = mr_sync_r[SYNC_N-1] == mr_sync_r[SYNC_N-2];
    wire mr_seen_low = !mr_sync_r[SYNC_N-1];
    assign mr_low_nxt = mr_agree ? mr_seen_low : mr_low_r;

    // Any cause keeps or forces the reset
    wire uv_cause    = uv;
    wire mr_cause    = mr_low_r;
    wire cause       = uv_cause || mr_cause;

    // Timer runs only while waiting out the hold time
    wire timing      = (state_nxt == ST_TIMING);
    wire tmr_done    = (tmr_r >= TMR_END);
    assign tmr_nxt   = timing ? tmr_r + TW'(1) : '0;

    // HOLD:   a cause stands, the reset is asserted
    // TIMING: no cause, the hold time is being counted out
    // RUN:    released until the next cause
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HOLD: begin
                if (!cause)
                    state_nxt = ST_TIMING;
            end
            ST_TIMING: begin
                if (cause)
                    state_nxt = ST_HOLD;
                else if (tmr_done)
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (cause)
                    state_nxt = ST_HOLD;
            end
            default: state_nxt = ST_HOLD;
        endcase
    end

    // A new cause during timing restarts the full hold time
    wire assert_nxt  = (state_nxt != ST_RUN);

    // One internal state drives every polarity variant:
    //   active high        out follows the state, always driven
    //   active low         out is its inverse, always driven
    //   open drain         out stays low, only the enable follows,
    //                      so a shared processor pin may pull low too
    wire hi_out      = assert_nxt;
    wire lo_out      = !assert_nxt;
    wire od_oe       = assert_nxt;

    assign pin_out_nxt = POL_IS_HI ? hi_out :
                         (POL_IS_OD ? 1'b0 : lo_out);
    assign pin_oe_nxt  = POL_IS_OD ? od_oe : 1'b1;
    assign pin_nxt     = '{level: assert_nxt, out: pin_out_nxt,
                           oe: pin_oe_nxt};

    // Value the pin takes while the block is held in reset
    assign pin_rst     = '{level: 1'b1, out: POL_IS_HI, oe: 1'b1};

    // Pin samples; only the second flop reads the first.
    // Reset to released so no false press follows reset.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            mr_sync_r <= '1;
        end else begin
            mr_sync_r <= mr_sync_nxt;
        end
    end

    // Filtered manual reset level, held while the samples disagree
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            mr_low_r <= 1'b0;
        end else begin
            mr_low_r <= mr_low_nxt;
        end
    end

    // Hold-time counter, cleared whenever it is not counting
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_nxt;
        end
    end

    // Reset value is ST_HOLD so power-on always yields a full pulse
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Internal reset state, active high whatever the pin polarity
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rst_active_r <= pin_rst.level;
        end else begin
            rst_active_r <= pin_nxt.level;
        end
    end

    // Pin value, registered so the pin never glitches
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rst_out <= pin_rst.out;
        end else begin
            rst_out <= pin_nxt.out;
        end
    end

    // Pin enable, registered on the same edge as the value
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rst_oe <= pin_rst.oe;
        end else begin
            rst_oe <= pin_nxt.oe;
        end
    end
endmodule
`default_nettype wire

// file: hw/uv_detect.sv
// Undervoltage decision with hysteresis and depth-weighted glitch rejection
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_cfg.svh"
module uv_detect #(
    parameter int MW      = 12,
    parameter int CW      = 16,
    parameter int GLITCH  = `GLITCH_CYCLES,
    parameter int GDEEP   = `GLITCH_DEEP_CYCLES
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    // Sampled monitor level in millivolts
    input  wire logic [MW-1:0] level_mv,
    // Filtered undervoltage flag
    output logic               uv_r
);
    localparam logic [MW-1:0] VREF = MW'(`VREF_MV);
    localparam logic [MW-1:0] VHI  = MW'(`VREF_MV + `HYST_MV);
    localparam logic [MW-1:0] VDEEP = MW'(`VREF_MV - `DEEP_MV);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire           below = level_mv < VREF;
    wire           above = level_mv >= VHI;
    wire           deep  = level_mv < VDEEP;
    wire [CW-1:0]  limit = deep ? CW'(GDEEP) : CW'(GLITCH);
    wire           trip  = below && (cnt_r >= limit - CW'(1));

    // Deeper dips need less time below threshold to count
    assign cnt_nxt = !below ? '0 : (trip ? cnt_r : cnt_r + CW'(1));

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_r <= '0;
            uv_r  <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            if (trip)
                uv_r <= 1'b1;
            else if (above)
                uv_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: test/reset_gen_monitor.sv
// Port checker of the reset generator
`timescale 1ns/100ps
`default_nettype none
module reset_gen_monitor #(
    parameter int         TRST     = 20,
    parameter int         GLITCH   = 8,
    parameter logic [1:0] POLARITY = 2'h1
) (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [11:0] level_mv,
    input wire logic        manual_reset_n,
    input wire logic        manual_reset_n_oe,
    input wire logic        rst_out,
    input wire logic        rst_oe,
    input wire logic        rst_active_r
);
    int         low_cnt;
    int         quiet_cnt;
    wire logic  low = level_mv < 12'h12C;
    // Pin driven low; the block sees it through a three-flop synchroniser
    wire logic  mr_low_in = manual_reset_n_oe && !manual_reset_n;
    wire logic  exp_out = (POLARITY == 2'h0) ? rst_active_r :
                          ((POLARITY == 2'h2) ? 1'b0 : !rst_active_r);
    wire logic  exp_oe  = (POLARITY == 2'h2) ? rst_active_r : 1'b1;
    // Quiet uses the upper hysteresis edge, so 300..302 is never quiet
    wire logic  quiet = level_mv >= 12'h12F && (manual_reset_n || !manual_reset_n_oe);
    always_ff @(posedge clk_sys) begin
        low_cnt   <= (!nrst || !low) ? 0 : low_cnt + 1;
        quiet_cnt <= (!nrst || !quiet) ? 0 : quiet_cnt + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_mr_asserts: assert property (mr_low_in[*5] |=> rst_active_r) else $error("manual reset missed");
    a_pol_follow: assert property (rst_out == exp_out) else $error("bad polarity");
    a_pp_enable: assert property (rst_oe == exp_oe) else $error("bad pin enable");
    a_hold_time: assert property ($fell(rst_active_r) |-> quiet_cnt >= TRST) else $error("release too early");
    a_uv_trips: assert property (low_cnt >= GLITCH + 4 |-> rst_active_r) else $error("undervoltage missed");
    a_dip_ignored: assert property (!rst_active_r && low_cnt == 0 && manual_reset_n |=> !rst_active_r) else $error("dip not ignored");
    a_open_released: assert property (!rst_active_r && low_cnt == 0 && !manual_reset_n_oe |=> !rst_active_r) else $error("open pin reset");
    a_power_on: assert property ($rose(nrst) |-> rst_active_r) else $error("no power-on reset");
    cover property ($fell(rst_active_r));
    cover property (low_cnt == GLITCH + 4);
    cover property (!manual_reset_n_oe);
endmodule
`default_nettype wire

// file: test/reset_partner.sv
// Processor reset pin and manual reset source
`timescale 1ns/100ps
`default_nettype none
module reset_partner (
    // Generator reset pin
    input  wire logic rst_out,
    input  wire logic rst_oe,
    // Manual reset source
    input  wire logic mr_drive,
    input  wire logic mr_level,
    // Wire levels
    output logic      cpu_rst_n,
    output logic      mr_pin
);
    // Released lines fall back to their pull-ups
    assign cpu_rst_n = rst_oe ? rst_out : 1'b1;
    assign mr_pin    = mr_drive ? mr_level : 1'b1;
endmodule
`default_nettype wire

// file: test/supply_supervisor_reset_gen_tb.sv
// Self-checking bench of the reset generator
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_reset_gen_tb;
    logic        clk_sys = 0, nrst = 0, mr_drive = 1, mr_level = 1;
    logic [11:0] level_mv = 12'h14A;
    wire logic   rst_out, rst_oe, rst_active_r, cpu_rst_n, mr_pin;
    wire logic   rst_out_od, rst_oe_od, rst_active_od, cpu_rst_od;
    int          err_total = 0, total_checks = 0, n;
    always #2 clk_sys = ~clk_sys;
    supply_supervisor_reset_gen #(.TRST(20), .GLITCH(8), .GDEEP(2)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .level_mv(level_mv),
        .manual_reset_n(mr_pin), .manual_reset_n_oe(mr_drive),
        .rst_out(rst_out), .rst_oe(rst_oe), .rst_active_r(rst_active_r));
    reset_partner far (.rst_out(rst_out), .rst_oe(rst_oe), .mr_drive(mr_drive),
        .mr_level(mr_level), .cpu_rst_n(cpu_rst_n), .mr_pin(mr_pin));
    // Open-drain variant on the same stimulus
    supply_supervisor_reset_gen #(.POLARITY(2'h2), .TRST(20), .GLITCH(8),
        .GDEEP(2)) dut_od (
        .clk_sys(clk_sys), .nrst(nrst), .level_mv(level_mv),
        .manual_reset_n(mr_pin), .manual_reset_n_oe(mr_drive),
        .rst_out(rst_out_od), .rst_oe(rst_oe_od),
        .rst_active_r(rst_active_od));
    reset_partner far_od (.rst_out(rst_out_od), .rst_oe(rst_oe_od),
        .mr_drive(mr_drive), .mr_level(mr_level), .cpu_rst_n(cpu_rst_od),
        .mr_pin());
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t: saw %b want %b", $time, seen, exp);
        end
    endtask
    task step(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    // Bounded wait; n is the number of cycles until release
    task wait_free;
        n = 0;
        while (rst_active_r !== 1'b0 && n < 200) begin step(1); n++; end
        if (n == 200) begin err_total++; $display("MISMATCH %0t: stuck", $time); report_and_stop(); end
    endtask
    task t_manual;
        mr_level = 0; step(5); chk(rst_active_r, 1);
        step(5); chk(rst_active_r, 1);
        mr_level = 1; wait_free; chk(n >= 20, 1);
    endtask
    task t_open;
        mr_drive = 0; mr_level = 0; step(10); chk(rst_active_r, 0);
        mr_drive = 1; mr_level = 1;
    endtask
    task t_dips;
        level_mv = 12'h0FA; step(3); level_mv = 12'h14A; step(3);
        chk(rst_active_r, 0);
        level_mv = 12'h096; step(1); level_mv = 12'h14A; step(3);
        chk(rst_active_r, 0);
        level_mv = 12'h096; step(6); chk(rst_active_r, 1);
        level_mv = 12'h14A; wait_free;
    endtask
    task t_uv;
        level_mv = 12'h0FA; step(12); chk(rst_active_r, 1);
        level_mv = 12'h12D; step(40); chk(rst_active_r, 1);
        level_mv = 12'h14A; wait_free; chk(n >= 20, 1);
        chk(cpu_rst_n, 1);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        #1 nrst = 1;
        chk(rst_active_r, 1);
        chk(cpu_rst_n, 0);
        chk(cpu_rst_od, 0);
        chk(rst_oe_od, 1);
        wait_free; chk(n >= 20, 1);
        chk(rst_active_od, 0);
        chk(rst_oe_od, 0);
        chk(cpu_rst_od, 1);
        t_manual; t_open; t_dips; t_uv;
        report_and_stop();
    end
endmodule
bind supply_supervisor_reset_gen reset_gen_monitor #(.TRST(TRST), .GLITCH(GLITCH),
    .POLARITY(POLARITY)) mon (
    .clk_sys(clk_sys), .nrst(nrst), .level_mv(level_mv),
    .manual_reset_n(manual_reset_n), .manual_reset_n_oe(manual_reset_n_oe),
    .rst_out(rst_out), .rst_oe(rst_oe), .rst_active_r(rst_active_r));
`default_nettype wire
